/* File: ecrg_pkg.sv */
// shared constants and types for the egress cell routing glue
package ecrg_pkg;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 5;
  // field positions inside the first prepend word
  localparam int ROUTE_BIT_POS = 15;
  localparam int ADDR_LSB = 0;
  // cell geometry in words (16-bit words by default)
  localparam int PREPEND_WORDS = 3;
  localparam int PAYLOAD_WORDS = 27;
  localparam int POSTPEND_WORDS = 2;
  localparam int MAX_PREPOST = 10;
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] CNT_RESET = 6'h00;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 5'h00;

  typedef enum logic [2:0] {
    ECRG_IDLE    = 3'b000,
    ECRG_FETCH   = 3'b001,
    ECRG_PARSE   = 3'b011,
    ECRG_STRIP   = 3'b010,
    ECRG_WAIT    = 3'b110,
    ECRG_PAYLOAD = 3'b111,
    ECRG_POST    = 3'b101,
    ECRG_SWITCH  = 3'b100
  } ecrg_state_t;
endpackage

/* File: ecrg_sync.sv */
// three-stage synchroniser for a pin level
`timescale 1ns/10ps
module ecrg_sync (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic pin_in,
  output logic level_out
);
  typedef struct packed {
    logic [2:0] stage;
    logic level;
  } ecrg_sync_t;
  ecrg_sync_t st_ff;
  ecrg_sync_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.stage = {st_ff.stage[1:0], pin_in};
    // a change is accepted only once stages two and three agree
    if (st_ff.stage[1] == st_ff.stage[2]) begin
      nxt_st.level = st_ff.stage[2];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_ff <= '0;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  assign level_out = st_ff.level;
endmodule

/* File: ecrg_top.sv */
// egress cell routing glue: routes processor cells to switch or phy ports
`timescale 1ns/10ps
module ecrg_top #(
  parameter int DATA_W = ecrg_pkg::DATA_W,
  parameter int PREPEND_WORDS = ecrg_pkg::PREPEND_WORDS,
  parameter int PAYLOAD_WORDS = ecrg_pkg::PAYLOAD_WORDS,
  parameter int POSTPEND_WORDS = ecrg_pkg::POSTPEND_WORDS
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic cell_out_available,
  input wire logic cell_out_first_word,
  input wire logic [DATA_W-1:0] cell_out_data,
  output logic cell_out_read_en,
  input wire logic sw_read_en,
  output logic sw_cell_available,
  output logic [DATA_W-1:0] sw_data,
  input wire logic phy_cell_space,
  output logic phy_write_en,
  output logic phy_first_word,
  output logic [ecrg_pkg::ADDR_W-1:0] phy_addr,
  output logic [DATA_W-1:0] phy_data,
  output logic route_to_switch
);
  // one global word count serves every cell; the first word is routing
  localparam logic [ecrg_pkg::CNT_W-1:0] PRE_LAST =
    ecrg_pkg::CNT_W'(PREPEND_WORDS - 2);
  // the read in the wait state fetches payload word one, so one less here
  localparam logic [ecrg_pkg::CNT_W-1:0] PAY_LAST =
    ecrg_pkg::CNT_W'(PAYLOAD_WORDS - 2);
  localparam logic [ecrg_pkg::CNT_W-1:0] POST_LAST =
    ecrg_pkg::CNT_W'(POSTPEND_WORDS - 1);

  typedef struct packed {
    ecrg_pkg::ecrg_state_t state;
    logic [ecrg_pkg::CNT_W-1:0] cnt;
    logic to_switch;
    logic [ecrg_pkg::ADDR_W-1:0] addr;
    logic wr_en;
    logic first;
    logic bus_pay;
    logic bus_first;
    logic hold;
    logic [DATA_W-1:0] data;
  } ecrg_top_t;

  ecrg_top_t st_ff;
  ecrg_top_t nxt_st;
  logic space_sync;
  logic glue_rd;

  // cell space comes from a phy pin, so it is synchronised
  ecrg_sync u_space_sync (
    .ref_clk(ref_clk),
    .reset(reset),
    .clk_en(clk_en),
    .pin_in(phy_cell_space),
    .level_out(space_sync)
  );

  always_comb begin
    nxt_st = st_ff;
    // a payload word reaches the bus one cycle after its read and is
    // registered one cycle later, so the strobes trail the read pipe
    nxt_st.wr_en = st_ff.bus_pay;
    nxt_st.first = st_ff.bus_first;
    nxt_st.bus_pay = 1'b0;
    nxt_st.bus_first = 1'b0;
    nxt_st.hold = 1'b0;
    nxt_st.data = cell_out_data;
    glue_rd = 1'b0;
    unique case (st_ff.state)
      ecrg_pkg::ECRG_IDLE: begin
        // availability still stands the cycle after the last postpend read
        if (!st_ff.hold && cell_out_available) begin
          nxt_st.state = ecrg_pkg::ECRG_FETCH;
        end
      end
      ecrg_pkg::ECRG_FETCH: begin
        glue_rd = 1'b1;
        nxt_st.state = ecrg_pkg::ECRG_PARSE;
      end
      ecrg_pkg::ECRG_PARSE: begin
        // read paused while the first word is on the bus
        if (cell_out_first_word) begin
          nxt_st.to_switch = cell_out_data[ecrg_pkg::ROUTE_BIT_POS];
          nxt_st.addr = cell_out_data[ecrg_pkg::ADDR_LSB +:
            ecrg_pkg::ADDR_W];
          nxt_st.cnt = ecrg_pkg::CNT_RESET;
          if (cell_out_data[ecrg_pkg::ROUTE_BIT_POS]) begin
            nxt_st.state = ecrg_pkg::ECRG_SWITCH;
          end else if (PREPEND_WORDS > 1) begin
            nxt_st.state = ecrg_pkg::ECRG_STRIP;
          end else begin
            nxt_st.state = ecrg_pkg::ECRG_WAIT;
          end
        end
      end
      ecrg_pkg::ECRG_STRIP: begin
        glue_rd = 1'b1;
        nxt_st.cnt = st_ff.cnt + 1'b1;
        if (st_ff.cnt == PRE_LAST) begin
          nxt_st.cnt = ecrg_pkg::CNT_RESET;
          nxt_st.state = ecrg_pkg::ECRG_WAIT;
        end
      end
      ecrg_pkg::ECRG_WAIT: begin
        // cell space is checked only after the last prepend word left
        if (space_sync) begin
          glue_rd = 1'b1;
          nxt_st.state = ecrg_pkg::ECRG_PAYLOAD;
          nxt_st.bus_pay = 1'b1;
          nxt_st.bus_first = 1'b1;
        end
      end
      ecrg_pkg::ECRG_PAYLOAD: begin
        glue_rd = 1'b1;
        nxt_st.bus_pay = 1'b1;
        nxt_st.cnt = st_ff.cnt + 1'b1;
        if (st_ff.cnt == PAY_LAST) begin
          nxt_st.cnt = ecrg_pkg::CNT_RESET;
          if (POSTPEND_WORDS > 0) begin
            nxt_st.state = ecrg_pkg::ECRG_POST;
          end else begin
            nxt_st.state = ecrg_pkg::ECRG_IDLE;
            nxt_st.hold = 1'b1;
          end
        end
      end
      ecrg_pkg::ECRG_POST: begin
        // postpend words are read but never strobed into the phy
        glue_rd = 1'b1;
        nxt_st.cnt = st_ff.cnt + 1'b1;
        if (st_ff.cnt == POST_LAST) begin
          nxt_st.cnt = ecrg_pkg::CNT_RESET;
          nxt_st.state = ecrg_pkg::ECRG_IDLE;
          nxt_st.hold = 1'b1;
        end
      end
      ecrg_pkg::ECRG_SWITCH: begin
        // the switch owns the read until the processor drops availability
        if (!cell_out_available) begin
          nxt_st.state = ecrg_pkg::ECRG_IDLE;
        end
      end
      default: begin
        nxt_st.state = ecrg_pkg::ECRG_IDLE;
      end
    endcase
  end

  // both sides run on ref_clk; no crossing is attempted here
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_ff.state <= ecrg_pkg::ECRG_IDLE;
      st_ff.bus_pay <= 1'b0;
      st_ff.bus_first <= 1'b0;
      st_ff.hold <= 1'b0;
      st_ff.cnt <= ecrg_pkg::CNT_RESET;
      st_ff.to_switch <= 1'b0;
      st_ff.addr <= ecrg_pkg::ADDR_RESET;
      st_ff.wr_en <= 1'b0;
      st_ff.first <= 1'b0;
      st_ff.data <= '0;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  // read enable is combinational so the fetch shows the cycle after idle
  always_comb begin
    if (st_ff.state == ecrg_pkg::ECRG_SWITCH) begin
      cell_out_read_en = sw_read_en;
    end else begin
      cell_out_read_en = glue_rd;
    end
  end

  assign sw_cell_available = (st_ff.state == ecrg_pkg::ECRG_SWITCH) &&
    cell_out_available;
  // same width on both sides, so data passes unchanged through one register
  // switch cells pass unchanged, so they keep their own framing
  assign sw_data = st_ff.data;
  assign phy_data = st_ff.data;
  assign phy_write_en = st_ff.wr_en;
  assign phy_first_word = st_ff.first;
  assign phy_addr = st_ff.addr;
  assign route_to_switch = st_ff.to_switch;
endmodule

/* File: ecrg_top_props.sv */
// assertion checker for the egress cell routing glue
`timescale 1ns/10ps
module ecrg_top_props #(
  parameter int PAYLOAD_WORDS = 27
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic cell_out_available,
  input wire logic cell_out_first_word,
  input wire logic cell_out_read_en,
  input wire logic phy_write_en,
  input wire logic phy_first_word,
  input wire logic [ecrg_pkg::ADDR_W-1:0] phy_addr,
  input wire logic route_to_switch
);
  logic [7:0] wen_run_ff;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // run length of the write enable, read when it falls
  always_ff @(posedge ref_clk) begin
    if (reset) wen_run_ff <= 8'h00;
    else wen_run_ff <= phy_write_en ? wen_run_ff + 8'h01 : 8'h00;
  end
  fetch_on_avail_a: assert property ($rose(cell_out_available) |=>
    cell_out_read_en) else $error("no fetch after cell available");
  pause_on_first_a: assert property (cell_out_first_word |->
    !cell_out_read_en) else $error("read not paused at first word");
  prepend_quiet_a: assert property (cell_out_first_word |->
    !phy_write_en ##1 !phy_write_en) else $error("write during prepend");
  write_after_read_a: assert property ($rose(phy_write_en) |->
    $past(cell_out_read_en)) else $error("write not one after read");
  first_pulse_a: assert property ($rose(phy_write_en) ==
    phy_first_word) else $error("first word pulse misplaced");
  switch_no_write_a: assert property (route_to_switch |->
    !phy_write_en) else $error("phy written for switch cell");
  route_held_a: assert property (phy_write_en && $past(phy_write_en) |->
    $stable(phy_addr) && $stable(route_to_switch)) else $error("route moved");
  cell_length_a: assert property ($fell(phy_write_en) |->
    wen_run_ff == 8'(PAYLOAD_WORDS)) else $error("payload length wrong");
  cover property ($rose(phy_write_en));
  cover property (route_to_switch && cell_out_read_en);
  cover property ($fell(cell_out_available));
endmodule
bind ecrg_top ecrg_top_props #(.PAYLOAD_WORDS(PAYLOAD_WORDS)) ecrg_top_props_i (
  .ref_clk, .reset, .cell_out_available, .cell_out_first_word,
  .cell_out_read_en, .phy_write_en, .phy_first_word, .phy_addr,
  .route_to_switch);

/* File: ecrg_proc_model.sv */
// model of the processor cell output port
`timescale 1ns/10ps
module ecrg_proc_model #(
  parameter int LEN = 32
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic start,
  input wire logic [15:0] hdr,
  input wire logic [15:0] base,
  input wire logic cell_out_read_en,
  output logic cell_out_available,
  output logic cell_out_first_word,
  output logic [15:0] cell_out_data
);
  int idx;
  always @(posedge ref_clk) begin
    cell_out_first_word <= 1'b0;
    // unread cycles toggle so a stale word is never mistaken for data
    cell_out_data <= ~cell_out_data;
    if (reset) begin
      cell_out_available <= 1'b0;
      cell_out_data <= 16'h0000;
      idx <= 0;
    end else if (!cell_out_available) begin
      cell_out_available <= start;
      idx <= 0;
    end else if (idx == LEN) begin
      cell_out_available <= 1'b0;
    end else if (cell_out_read_en) begin
      cell_out_first_word <= (idx == 0);
      cell_out_data <= (idx == 0) ? hdr : base + 16'(idx);
      idx <= idx + 1;
    end
  end
endmodule

/* File: ecrg_top_bench.sv */
// self-checking testbench for the egress cell routing glue
`timescale 1ns/10ps
module ecrg_top_bench;
  localparam int PAY = 6;
  localparam int PRE = ecrg_pkg::PREPEND_WORDS;
  localparam int LEN = PRE + PAY + ecrg_pkg::POSTPEND_WORDS;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic start = 1'b0;
  logic sw_read_en = 1'b0;
  logic phy_cell_space = 1'b1;
  logic [15:0] hdr = 16'h0000;
  logic [15:0] base = 16'h0000;
  logic cell_out_available, cell_out_first_word, cell_out_read_en;
  logic phy_write_en, phy_first_word, route_to_switch;
  logic [15:0] cell_out_data, phy_data;
  logic [4:0] phy_addr;
  logic [21:0] exp_q[$];
  int fail_count = 0;
  int n_tests = 0;
  always #5 ref_clk = ~ref_clk;
  ecrg_top #(.PAYLOAD_WORDS(PAY)) ecrg_top_i (.ref_clk, .reset,
    .clk_en(1'b1), .cell_out_available, .cell_out_first_word,
    .cell_out_data, .cell_out_read_en, .sw_read_en, .sw_cell_available(),
    .sw_data(), .phy_cell_space, .phy_write_en, .phy_first_word,
    .phy_addr, .phy_data, .route_to_switch);
  ecrg_proc_model #(.LEN(LEN)) ecrg_proc_model_i (.ref_clk, .reset, .start,
    .hdr, .base, .cell_out_read_en, .cell_out_available,
    .cell_out_first_word, .cell_out_data);
  task automatic check(input logic [21:0] seen, input logic [21:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("tests %0d failures %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic send_cell(input logic to_sw, input logic stall);
    logic [4:0] addr;
    addr = 5'($urandom);
    @(posedge ref_clk);
    hdr <= {to_sw, 10'h000, addr};
    base <= 16'($urandom);
    start <= 1'b1;
    phy_cell_space <= !stall;
    @(posedge ref_clk);
    start <= 1'b0;
    for (int k = 0; k < PAY && !to_sw; k++)
      exp_q.push_back({k == 0, addr, base + 16'(PRE + k)});
    @(posedge ref_clk);
    if (stall) begin
      repeat (20) @(posedge ref_clk);
      check(22'(phy_write_en), 22'h000000);
      phy_cell_space <= 1'b1;
    end
    for (int k = 0; k < 300 && cell_out_available; k++) @(posedge ref_clk);
    check(22'(route_to_switch), 22'(to_sw));
    repeat (2) @(posedge ref_clk);
  endtask
  // switch side reads at random so its stalls reach the read enable
  always @(posedge ref_clk) sw_read_en <= 1'($urandom);
  // sampled mid-cycle, where the registered outputs have settled
  always @(negedge ref_clk) begin
    if (!reset && phy_write_en) begin
      if (exp_q.size() == 0) check(22'h3FFFFF, 22'h000000);
      else check({phy_first_word, phy_addr, phy_data}, exp_q.pop_front());
    end
  end
  initial begin
    repeat (3000) @(posedge ref_clk);
    fail_count++;
    print_verdict();
  end
  initial begin
    void'($urandom(32'h891AA941));
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    for (int c = 0; c < 8; c++) send_cell(c % 3 == 2, c == 0);
    check(22'(exp_q.size()), 22'h000000);
    print_verdict();
  end
endmodule
